/* rtl/reset_source_control_regs.vh */
// Constants for the reset source controller: register map,
// field positions, reset values and start-up timing.
// Assumes a single 50 MHz clock and a 32-bit Wishbone slave port.
`ifndef RESET_SOURCE_CONTROL_REGS_VH
`define RESET_SOURCE_CONTROL_REGS_VH

// Register byte offsets
`define OFS_KEY 8'h00
`define OFS_MODE 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10

// Reset-pin key values
`define KEY_IO 8'h55
`define KEY_EXT 8'hAA
`define KEY_RESET 8'h55

// Mode and flag register fields
`define MODE_IDLE_KEEP 7
`define MODE_KEY_FAULT 3
`define MODE_LOW_VOLT 2
`define MODE_WDT_KEY 0
`define MODE_RW_MASK 8'h8D

// Status register fields (read only)
`define STAT_TIMEOUT 0
`define STAT_PWR_DOWN 1

// Event bits, shared by interrupt status and mask
`define EV_PIN 0
`define EV_LOW_VOLT 1
`define EV_KEY_FAULT 2
`define EV_WDT_RUN 3
`define EV_WDT_SLEEP 4
`define EV_WDT_KEY 5
`define EV_WIDTH 6

// Timing: the power-on and pin figures in microseconds, the rest in clock cycles, and the clock rate in MHz
`define CLK_MHZ 50
`define T_POR_US 50000
`define T_PIN_US 16700
`define KEY_FAULT_CYC 2
`define LVR_QUAL_CYC 1000

`endif

/* rtl/reset_source_control.v */
// Reset source controller: merges power-on, reset pin, key fault,
// low-voltage, watchdog key-fault and run-mode watchdog time-out causes into the core reset, times the
// start-up delay and keeps sticky cause flags for software.
// Assumes one clock, inputs synchronous to it, and a Wishbone master.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "reset_source_control_regs.vh"

module reset_source_control #(
	parameter POR_DELAY_CYC = `T_POR_US * `CLK_MHZ,
	parameter PIN_DELAY_CYC = `T_PIN_US * `CLK_MHZ,
	parameter LVR_QUAL_CYC = `LVR_QUAL_CYC
) (
	input wire clk,
	input wire reset_n,
	input wire ce,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire external_clear_pin_n,
	input wire undervoltage_monitor,
	input wire wdt_timeout,
	input wire wdt_key_fault,
	input wire sleep_idle_mode,
	input wire power_down,
	output reg core_reset_r,
	output reg ports_preset_r,
	output reg pc_sp_clear_r,
	output reg ext_pin_select_r,
	output reg idle_clock_keep_r,
	output reg irq_r
);

	// Sequencer states
	localparam [1:0] ST_HOLD = 2'b00;
	localparam [1:0] ST_DELAY = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	// Delay targets, sized to the counter
	localparam [21:0] POR_LAST = POR_DELAY_CYC - 1;
	localparam [21:0] PIN_LAST = PIN_DELAY_CYC - 1;
	localparam [15:0] LVR_LAST = LVR_QUAL_CYC - 1;

	// Key decode, used for the key fault check
	function key_valid;
		input [7:0] k;
		begin
			key_valid = (k == `KEY_IO) || (k == `KEY_EXT);
		end
	endfunction

	reg [1:0] state_r; // Sequencer state
	reg [21:0] cnt_r; // Start-up delay counter
	reg [21:0] last_r; // Target of the running delay
	reg [7:0] key_r; // Reset pin function key
	reg key_fault_flag_r; // Sticky flag, bit 3
	reg low_volt_flag_r; // Sticky flag, bit 2
	reg wdt_key_flag_r; // Sticky flag, bit 0
	reg timeout_flag_r; // Watchdog time-out flag
	reg power_down_flag_r; // Power-down flag
	reg [`EV_WIDTH-1:0] irq_stat_r; // Sticky events, read clears
	reg [`EV_WIDTH-1:0] irq_mask_r; // Interrupt enables
	reg [1:0] key_cnt_r; // Key fault qualifying counter
	reg [15:0] lvr_cnt_r; // Low-voltage qualifying counter
	reg lvr_hold_r; // Qualified low-voltage condition
	reg pin_s1_r; // Pin synchroniser, first stage
	reg pin_s2_r; // Pin synchroniser, second stage
	reg lv_s1_r; // Monitor synchroniser, first stage
	reg lv_s2_r; // Monitor synchroniser, second stage

	// Bus access decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_rd = bus_req & ~wb_we_i;

	// Reset causes; pin counts only when the key selects it
	wire pin_low = ~pin_s2_r & (key_r == `KEY_EXT);
	wire key_fire = (key_cnt_r == `KEY_FAULT_CYC);
	wire wdt_run = wdt_timeout & ~sleep_idle_mode;
	wire wdt_sleep = wdt_timeout & sleep_idle_mode;
	wire full_trig = lvr_hold_r | pin_low | key_fire | wdt_run | wdt_key_fault;

	// Event vector for the interrupt status
	wire [`EV_WIDTH-1:0] events;
	assign events[`EV_PIN] = pin_low & (state_r != ST_HOLD);
	assign events[`EV_LOW_VOLT] = lvr_hold_r & (state_r != ST_HOLD);
	assign events[`EV_KEY_FAULT] = key_fire;
	assign events[`EV_WDT_RUN] = wdt_run;
	assign events[`EV_WDT_SLEEP] = wdt_sleep;
	assign events[`EV_WDT_KEY] = wdt_key_fault;

	// Two-stage synchronisers; only the second stage is read
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			lv_s1_r <= 1'b0;
			lv_s2_r <= 1'b0;
		end else if (ce) begin
			pin_s1_r <= external_clear_pin_n;
			pin_s2_r <= pin_s1_r;
			lv_s1_r <= undervoltage_monitor;
			lv_s2_r <= lv_s1_r;
		end
	end

	// Low-voltage qualifier: the dip must outlast the window
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lvr_cnt_r <= 16'h0000;
			lvr_hold_r <= 1'b0;
		end else if (ce) begin
			if (!lv_s2_r || power_down) begin
				// Short dip or power-down: forget it
				lvr_cnt_r <= 16'h0000;
				lvr_hold_r <= 1'b0;
			end else if (lvr_cnt_r == LVR_LAST) begin
				lvr_hold_r <= 1'b1;
			end else begin
				lvr_cnt_r <= lvr_cnt_r + 16'h0001;
			end
		end
	end

	// Key fault timer: a bad key resets after two cycles
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_cnt_r <= 2'b00;
		end else if (ce) begin
			if (key_valid(key_r) || key_fire) begin
				key_cnt_r <= 2'b00;
			end else begin
				key_cnt_r <= key_cnt_r + 2'b01;
			end
		end
	end

	// Reset sequencer: hold, start-up delay, run
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// Power-on: start the long delay at once
			state_r <= ST_DELAY;
			last_r <= POR_LAST;
			cnt_r <= 22'h000000;
			core_reset_r <= 1'b1;
			ports_preset_r <= 1'b1;
			pc_sp_clear_r <= 1'b0;
		end else if (ce) begin
			pc_sp_clear_r <= 1'b0;
			case (state_r)
				ST_HOLD: begin
					// Execution inhibited while a level cause persists
					cnt_r <= 22'h000000;
					if (!pin_low && !lvr_hold_r) begin
						state_r <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (pin_low || lvr_hold_r) begin
						state_r <= ST_HOLD;
						last_r <= lvr_hold_r ? POR_LAST : PIN_LAST;
					end else if (cnt_r == last_r) begin
						state_r <= ST_RUN;
						core_reset_r <= 1'b0;
						ports_preset_r <= 1'b0;
					end else begin
						cnt_r <= cnt_r + 22'h000001;
					end
				end
				ST_RUN: begin
					if (pin_low || lvr_hold_r) begin
						// Counter clears with the core, address zero follows
						state_r <= ST_HOLD;
						core_reset_r <= 1'b1;
						ports_preset_r <= 1'b1;
						last_r <= lvr_hold_r ? POR_LAST : PIN_LAST;
					end else if (full_trig) begin
						// Key or watchdog: a pulse cause, straight to delay
						state_r <= ST_DELAY;
						core_reset_r <= 1'b1;
						ports_preset_r <= 1'b1;
						cnt_r <= 22'h000000;
						last_r <= PIN_LAST;
					end else if (wdt_sleep) begin
						pc_sp_clear_r <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_HOLD;
					core_reset_r <= 1'b1;
				end
			endcase
		end
	end

	// Key register and idle clock bit: reloaded by full resets, except that a watchdog time-out reloads only the idle clock bit
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_r <= `KEY_RESET;
			idle_clock_keep_r <= 1'b0;
			ext_pin_select_r <= 1'b0;
		end else if (ce) begin
			if ((state_r == ST_RUN && (lvr_hold_r || key_fire || wdt_key_fault)) ||
				(state_r == ST_HOLD && !pin_low && !lvr_hold_r)) begin
				// Pin reset reloads on release, so the pin keeps holding while low
				// Watchdog time-out alone leaves the key untouched
				key_r <= `KEY_RESET;
				idle_clock_keep_r <= 1'b0;
			end else if (state_r == ST_RUN && wdt_run) begin
				idle_clock_keep_r <= 1'b0;
			end else if (bus_wr && wb_adr_i == `OFS_KEY) begin
				key_r <= wb_dat_i[7:0];
			end else if (bus_wr && wb_adr_i == `OFS_MODE) begin
				idle_clock_keep_r <= wb_dat_i[`MODE_IDLE_KEEP];
			end
			ext_pin_select_r <= (key_r == `KEY_EXT);
		end
	end

	// Sticky cause flags: hardware sets, software writes zero to clear
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_fault_flag_r <= 1'b0;
			low_volt_flag_r <= 1'b0;
			wdt_key_flag_r <= 1'b0;
		end else if (ce) begin
			// A write of one leaves a flag as it is; set beats clear
			if (bus_wr && wb_adr_i == `OFS_MODE) begin
				if (!wb_dat_i[`MODE_KEY_FAULT]) key_fault_flag_r <= 1'b0;
				if (!wb_dat_i[`MODE_LOW_VOLT]) low_volt_flag_r <= 1'b0;
				if (!wb_dat_i[`MODE_WDT_KEY]) wdt_key_flag_r <= 1'b0;
			end
			if (key_fire) key_fault_flag_r <= 1'b1;
			if (lvr_hold_r) low_volt_flag_r <= 1'b1;
			if (wdt_key_fault) wdt_key_flag_r <= 1'b1;
		end
	end

	// Time-out and power-down flags; only power-on clears them
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_flag_r <= 1'b0;
			power_down_flag_r <= 1'b0;
		end else if (ce) begin
			if (wdt_timeout) begin
				timeout_flag_r <= 1'b1;
			end
			if (wdt_sleep) begin
				power_down_flag_r <= 1'b1;
			end
		end
	end

	// Interrupt status, mask and output
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_r <= {`EV_WIDTH{1'b0}};
			irq_mask_r <= {`EV_WIDTH{1'b0}};
			irq_r <= 1'b0;
		end else if (ce) begin
			// Read clears, but a same-cycle event survives
			if (bus_rd && wb_adr_i == `OFS_IRQ_STAT) begin
				irq_stat_r <= events;
			end else begin
				irq_stat_r <= irq_stat_r | events;
			end
			if (bus_wr && wb_adr_i == `OFS_IRQ_MASK) begin
				irq_mask_r <= wb_dat_i[`EV_WIDTH-1:0];
			end
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Wishbone slave: one wait state, unmapped reads give zero
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h00000000;
			if (bus_rd) begin
				case (wb_adr_i)
					`OFS_KEY: wb_dat_o[7:0] <= key_r;
					`OFS_MODE: begin
						// Bits six to four and one stay zero
						wb_dat_o[7:0] <= {idle_clock_keep_r, 3'b000, key_fault_flag_r,
							low_volt_flag_r, 1'b0, wdt_key_flag_r};
					end
					`OFS_STATUS: begin
						wb_dat_o[`STAT_TIMEOUT] <= timeout_flag_r;
						wb_dat_o[`STAT_PWR_DOWN] <= power_down_flag_r;
					end
					`OFS_IRQ_STAT: wb_dat_o[`EV_WIDTH-1:0] <= irq_stat_r;
					`OFS_IRQ_MASK: wb_dat_o[`EV_WIDTH-1:0] <= irq_mask_r;
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

/* tb/reset_net.sv */
// Model of the reset pin network and the supply monitor.
// Assumes the bench commands pin pulls and sags by NBA.
`timescale 1ns/100ps
module reset_net (
	input logic hold_low,
	input logic sag,
	output logic clear_n,
	output logic uv
);
	// Pull-up resistor: a released pin reads high
	assign clear_n = !hold_low;
	// Monitor level follows the supply sag
	assign uv = sag;
endmodule

/* tb/reset_source_control_properties.sv */
// Checker for the reset source controller ports.
// Assumes bind to the top module; the supply qualification is tracked by counter.
`timescale 1ns/100ps
`include "reset_source_control_regs.vh"
module reset_source_control_properties #(
	parameter PIN_DELAY_CYC = 20,
	parameter LVR_QUAL_CYC = 4
) (
	input logic clk,
	input logic reset_n,
	input logic ce,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [31:0] wb_dat_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input logic external_clear_pin_n,
	input logic undervoltage_monitor,
	input logic wdt_timeout,
	input logic sleep_idle_mode,
	input logic power_down,
	input logic core_reset_r,
	input logic ports_preset_r,
	input logic pc_sp_clear_r,
	input logic ext_pin_select_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	int run_cnt; // Cycles of core reset so far
	int uv_cnt; // Cycles of qualifying low supply
	logic key_wr; // Acked key write
	assign key_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_KEY;
	// Counters for long holds, too long for repetition
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_cnt <= 0;
			uv_cnt <= 0;
		end else begin
			run_cnt <= core_reset_r ? run_cnt + 1 : 0;
			uv_cnt <= (undervoltage_monitor && !power_down) ? uv_cnt + 1 : 0;
		end
	end
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_ACK_NEXT: assert property ($rose(wb_cyc_i && wb_stb_i) && ce |=> wb_ack_o)
		else $error("no ack");
	AST_READ_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 0 &&
		(wb_adr_i != `OFS_MODE || (wb_dat_o & 32'h72) == 0)) else $error("bits not zero");
	AST_PORTS_CORE: assert property (ports_preset_r == core_reset_r)
		else $error("port preset apart from core reset");
	AST_SLEEP_PULSE: assert property (pc_sp_clear_r |->
		$past(wdt_timeout && sleep_idle_mode) || $past(wdt_timeout && sleep_idle_mode, 2))
		else $error("stray counter clear");
	AST_PIN_RESET: assert property ($fell(external_clear_pin_n) && ext_pin_select_r
		&& !core_reset_r |-> ##[1:4] core_reset_r) else $error("pin ignored");
	AST_LVR_QUAL: assert property (uv_cnt == LVR_QUAL_CYC + 5 |-> ##[0:3] core_reset_r)
		else $error("low supply ignored");
	AST_KEY_FAULT: assert property (key_wr && wb_dat_i[7:0] != `KEY_IO
		&& wb_dat_i[7:0] != `KEY_EXT |-> ##[1:5] core_reset_r) else $error("bad key ignored");
	AST_PIN_SELECT: assert property (key_wr && wb_dat_i[7:0] == `KEY_EXT
		|=> ##1 ext_pin_select_r) else $error("pin function not selected");
	AST_CORE_HOLD: assert property ($fell(core_reset_r) |-> run_cnt >= PIN_DELAY_CYC)
		else $error("start-up delay short");
endmodule
bind reset_source_control reset_source_control_properties #(
	.PIN_DELAY_CYC(PIN_DELAY_CYC),
	.LVR_QUAL_CYC(LVR_QUAL_CYC)
) i_props (.*);

/* tb/reset_source_control_bench.sv */
// Bench for the reset source controller: bus tasks and cause scenarios.
// Assumes shortened delays: 50 power-on, 20 pin, 4 qualify cycles.
`timescale 1ns/100ps
`include "reset_source_control_regs.vh"
module reset_source_control_bench;
	logic clk = 0, reset_n = 0, cyc = 0, we = 0, wdt = 0, wkey = 0;
	logic slp = 0, pdn = 0, hold = 0, sag = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rd;
	wire [31:0] dat_o;
	wire ack, pin_n, uv, core, ports, pcsp, extsel, idle, irq;
	int error_cnt = 0, checks = 0, cyc_cnt = 0, n, pcsp_cnt = 0;
	always #10 clk = ~clk;
	reset_source_control #(.POR_DELAY_CYC(50), .PIN_DELAY_CYC(20), .LVR_QUAL_CYC(4)) i_dut (
		.clk(clk), .reset_n(reset_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .external_clear_pin_n(pin_n), .undervoltage_monitor(uv),
		.wdt_timeout(wdt), .wdt_key_fault(wkey), .sleep_idle_mode(slp), .power_down(pdn),
		.core_reset_r(core), .ports_preset_r(ports), .pc_sp_clear_r(pcsp),
		.ext_pin_select_r(extsel), .idle_clock_keep_r(idle), .irq_r(irq));
	reset_net i_net (.hold_low(hold), .sag(sag), .clear_n(pin_n), .uv(uv));
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Classic cycle: hold until ack, take data, then drop for a cycle
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin tick(1); n++; end while (ack !== 1 && n < 20);
		rd = dat_o;
		cyc <= 0;
		tick(1);
	endtask
	task wait_core(input logic v);
		n = 0;
		while (core !== v && n < 400) begin tick(1); n++; end
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc_cnt++;
		pcsp_cnt += (pcsp === 1);
		if (cyc_cnt == 4000) begin error_cnt++; give_verdict; end
	end
	initial begin
		tick(1); chk("ports", ports, 1);
		@(posedge clk); reset_n <= 1;
		wait_core(0); chk("por delay", n >= 50, 1);
		bus(0, `OFS_KEY, 0); chk("key", rd, 8'h55);
		bus(0, `OFS_MODE, 0); chk("mode", rd, 0);
		bus(0, `OFS_STATUS, 0); chk("status", rd, 0);
		bus(0, 8'h40, 0); chk("unmapped", rd, 0);
		bus(1, `OFS_MODE, 8'h80); bus(0, `OFS_MODE, 0); chk("mode keep", rd, 8'h80);
		chk("idle keep", idle, 1);
		$display("power-on test done");
		bus(1, `OFS_KEY, 8'h3C); wait_core(1); chk("fault", n <= 5, 1);
		wait_core(0); bus(1, `OFS_IRQ_MASK, 8'h3F); tick(2); chk("irq", irq, 1);
		bus(0, `OFS_MODE, 0); chk("mode", rd, 8'h08);
		bus(0, `OFS_KEY, 0); chk("key", rd, 8'h55);
		bus(0, `OFS_IRQ_STAT, 0); chk("irq stat", rd, 8'h04);
		bus(1, `OFS_MODE, 8'h08); bus(0, `OFS_MODE, 0); chk("mode", rd, 8'h08);
		bus(1, `OFS_MODE, 0); bus(0, `OFS_MODE, 0); chk("mode", rd, 0);
		chk("irq off", irq, 0);
		$display("key fault test done");
		bus(1, `OFS_KEY, 8'hAA); chk("extsel", extsel, 1);
		hold <= 1; tick(10); chk("pin", core, 1);
		hold <= 0; wait_core(0); chk("pin delay", n >= 20, 1);
		bus(0, `OFS_KEY, 0); chk("key", rd, 8'h55);
		bus(0, `OFS_STATUS, 0); chk("status", rd, 0);
		$display("pin test done");
		sag <= 1; tick(2); sag <= 0; tick(8); chk("dip", core, 0);
		pdn <= 1; sag <= 1; tick(15); sag <= 0; tick(8); chk("pdown", core, 0);
		pdn <= 0; sag <= 1; tick(12); chk("lvr", core, 1);
		sag <= 0; wait_core(0); chk("lvr delay", n >= 50, 1);
		bus(0, `OFS_MODE, 0); chk("mode", rd, 8'h04);
		$display("supply test done");
		bus(1, `OFS_KEY, 8'hAA); wdt <= 1; tick(1); wdt <= 0;
		wait_core(1); chk("wdt", n <= 3, 1);
		wait_core(0); bus(0, `OFS_STATUS, 0); chk("status", rd, 8'h01);
		bus(0, `OFS_KEY, 0); chk("key", rd, 8'hAA);
		slp <= 1; wdt <= 1; tick(1); wdt <= 0; tick(4); chk("sleep", core, 0);
		chk("pc clear", pcsp_cnt, 1);
		bus(0, `OFS_STATUS, 0); chk("status", rd, 8'h03);
		bus(0, `OFS_MODE, 0); chk("mode", rd, 8'h04);
		$display("watchdog test done");
		give_verdict;
	end
endmodule
